// *** hdl/cell_balance_config_regs.sv ***
// configuration register bank for automated cell balancing, apb slave
// Overview of operation
// R01 - ten-bit cell 14 expiry, unit per mode
// R02 - all-ones expiry means never expire
// R03 - expiry resets zero, zero means expired
// R04 - automated mode blocks expiry and threshold writes
// R05 - scan active rejects lowest-cell selection, alert
// R06 - threshold read shows level and selection
// R07 - fourteen-bit level suspends balancing below it
// R08 - level resets to full scale
// R09 - selection clear loads written level
// R10 - selection set loads lowest cell result
// R11 - bipolar polarity forces full scale instead
// R12 - discharge or automated mode blocks delay writes
// R13 - notify period off, one, two, four hours
// R14 - notify timed in real time, not duty
// R15 - notify continues during shutdown line hold
// R16 - calibration period field, off to thirty-two
// R17 - balancing mode field encoding
// R18 - blocked write leaves register unchanged
module cell_balance_config_regs
    import cell_balance_pkg::*;
#(
    parameter longint notify_unit_cycles = cell_balance_pkg::notify_base_cycles,
    parameter int cells = 16
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement side
    input wire logic scan_active,
    input wire logic extreme_search_polarity,
    input wire logic [cell_balance_pkg::cell_idx_w-1:0] lowest_cell_index,
    input wire logic result_wr,
    input wire logic [cell_balance_pkg::cell_idx_w-1:0] result_idx,
    input wire logic [cell_balance_pkg::level_w-1:0] result_data,
    input wire logic [cell_balance_pkg::level_w-1:0] cell_reading,
    input wire logic balancing_running,
    input wire logic shutdown_line_hold,
    // block outputs
    output logic [cell_balance_pkg::expiry_w-1:0] cell14_expiry_time,
    output logic cell14_timer_forever,
    output logic cell14_timer_expired,
    output logic [cell_balance_pkg::level_w-1:0] undervolt_exit_level,
    output logic balance_suspend,
    output logic [cell_balance_pkg::mode_w-1:0] balance_mode_select,
    output logic [cell_balance_pkg::cal_w-1:0] calibration_period_select,
    output logic write_rejected_alert,
    output logic progress_notify_alert
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'b00) && (a[31:10] == 22'h0) && (a[9:2] == idx);
    endfunction

    logic access;
    logic wr_go;
    logic reject_now;
    logic notify_due;
    logic [level_w-1:0] level_q;
    logic sel_q;
    logic [notify_w-1:0] notify_period_q;
    logic [cal_w-1:0] cal_q;
    logic auto_mode;
    logic disch_or_auto;
    logic th_pending_q;
    logic [level_w-1:0] mem_rd;
    logic mapped;

    assign access = ce && psel && penable;
    assign wr_go = access && pwrite;
    // a rejected lowest-cell load must not touch sel or level, only raise the alert
    assign reject_now = wr_go && hit(paddr, idx_balance_undervolt_threshold) && !auto_mode
        && pwdata[sel_bit] && scan_active; // [R05]
    assign auto_mode = balance_mode_select[mode_auto_bit];
    assign disch_or_auto = auto_mode || (balance_mode_select == mode_discharge);
    assign mapped = hit(paddr, idx_cell14_balance_expiry) || hit(paddr, idx_balance_undervolt_threshold)
        || hit(paddr, idx_balance_delay_control) || hit(paddr, idx_balance_mode) || hit(paddr, idx_status);

    cell_result_mem #(.cells(cells), .aw(cell_idx_w), .dw(level_w)) u_mem (
        .pclk(pclk),
        .ce(ce),
        .wr_en(result_wr),
        .wr_addr(result_idx),
        .wr_data(result_data),
        .rd_addr(lowest_cell_index),
        .rd_data(mem_rd)
    );

    // ------------------------------------------------------------
    // apb answer: zero wait states
    // pready is loaded in the setup cycle, so ce low stalls the answer as well
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= read_zero;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= read_zero;
            if (hit(paddr, idx_cell14_balance_expiry)) begin
                prdata[expiry_w-1:0] <= cell14_expiry_time;
            end else if (hit(paddr, idx_balance_undervolt_threshold)) begin
                prdata[level_lsb +: level_w] <= level_q; // [R06]
                prdata[sel_bit] <= sel_q; // [R06]
            end else if (hit(paddr, idx_balance_delay_control)) begin
                prdata[notify_lsb +: notify_w] <= notify_period_q;
                prdata[cal_w-1:0] <= cal_q;
            end else if (hit(paddr, idx_balance_mode)) begin
                prdata[mode_w-1:0] <= balance_mode_select;
            end else if (hit(paddr, idx_status)) begin
                prdata[0] <= write_rejected_alert;
                prdata[1] <= progress_notify_alert;
            end
        end
    end

    // ------------------------------------------------------------
    // balancing mode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            balance_mode_select <= '0;
        end else if (wr_go && hit(paddr, idx_balance_mode)) begin
            balance_mode_select <= pwdata[mode_w-1:0]; // [R17]
        end
    end

    // ------------------------------------------------------------
    // cell 14 expiry
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell14_expiry_time <= expiry_reset; // [R03]
        end else if (wr_go && hit(paddr, idx_cell14_balance_expiry) && !auto_mode) begin // [R04] [R18]
            cell14_expiry_time <= pwdata[expiry_w-1:0]; // [R01]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell14_timer_forever <= 1'b0;
            cell14_timer_expired <= 1'b1;
        end else if (ce) begin
            cell14_timer_forever <= cell14_expiry_time == expiry_forever; // [R02]
            cell14_timer_expired <= cell14_expiry_time == expiry_reset; // [R03]
        end
    end

    // ------------------------------------------------------------
    // undervoltage threshold; lowest-cell load takes one extra cycle
    // because the result memory read is registered
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= level_full_scale; // [R08]
            sel_q <= 1'b0;
            th_pending_q <= 1'b0;
        end else if (ce) begin
            th_pending_q <= 1'b0;
            if (th_pending_q) begin
                level_q <= mem_rd; // [R10]
            end
            if (wr_go && hit(paddr, idx_balance_undervolt_threshold) && !auto_mode && !reject_now) begin // [R04] [R18]
                if (pwdata[sel_bit]) begin
                    sel_q <= 1'b1;
                    if (extreme_search_polarity) begin
                        level_q <= level_full_scale; // [R11]
                    end else begin
                        th_pending_q <= 1'b1; // [R10]
                    end
                end else begin
                    sel_q <= 1'b0;
                    level_q <= pwdata[level_lsb +: level_w]; // [R09]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write-rejected alert: sticky until software writes one to clear;
    // a new reject wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_rejected_alert <= 1'b0;
        end else if (ce) begin
            if (reject_now) begin
                write_rejected_alert <= 1'b1; // [R05]
            end else if (wr_go && hit(paddr, idx_status) && pwdata[0]) begin
                write_rejected_alert <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_exit_level <= level_full_scale;
            balance_suspend <= 1'b0;
        end else if (ce) begin
            undervolt_exit_level <= level_q;
            balance_suspend <= cell_reading < level_q; // [R07]
        end
    end

    // ------------------------------------------------------------
    // delay control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notify_period_q <= '0;
            cal_q <= '0;
        end else if (wr_go && hit(paddr, idx_balance_delay_control) && !disch_or_auto) begin // [R12] [R18]
            notify_period_q <= pwdata[notify_lsb +: notify_w]; // [R13]
            cal_q <= pwdata[cal_w-1:0]; // [R16]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calibration_period_select <= '0;
        end else if (ce) begin
            calibration_period_select <= cal_q; // [R16]
        end
    end

    // ------------------------------------------------------------
    // progress notification: real-time counter, cleared whenever notify is not live, so the
    // duty setting never stretches the period
    // ------------------------------------------------------------
    logic [47:0] tick_q;
    logic [2:0] hours_q;
    logic [2:0] hours_target;
    logic notify_live;

    always_comb begin
        case (notify_period_q)
            2'b01: hours_target = notify_hours_one;
            2'b10: hours_target = notify_hours_two;
            2'b11: hours_target = notify_hours_four;
            default: hours_target = '0;
        endcase
    end

    assign notify_live = (notify_period_q != '0) && (balancing_running || shutdown_line_hold); // [R15]
    // due on the last tick of the last hour of the selected period
    assign notify_due = notify_live && (tick_q == 48'(notify_unit_cycles - 1))
        && (hours_q + 3'h1 == hours_target);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
            hours_q <= '0;
        end else if (ce) begin
            if (!notify_live) begin
                tick_q <= '0;
                hours_q <= '0;
            end else if (tick_q == 48'(notify_unit_cycles - 1)) begin // [R14]
                tick_q <= '0;
                if (notify_due) begin
                    hours_q <= '0;
                end else begin
                    hours_q <= hours_q + 3'd1;
                end
            end else begin
                tick_q <= tick_q + 48'd1;
            end
        end
    end

    // a due notice wins over a same-cycle clear so no period is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            progress_notify_alert <= 1'b0;
        end else if (ce) begin
            if (notify_due) begin
                progress_notify_alert <= 1'b1; // [R13]
            end else if (wr_go && hit(paddr, idx_status) && pwdata[1]) begin
                progress_notify_alert <= 1'b0;
            end
        end
    end
endmodule // cell_balance_config_regs

// *** hdl/cell_balance_pkg.sv ***
// package of register map, field layouts and timing constants for the balance configuration bank
package cell_balance_pkg;
    // ------------------------------------------------------------
    // register indices (printed offsets), byte address = 4 * index
    // ------------------------------------------------------------
    localparam logic [7:0] idx_cell14_balance_expiry = 8'h7d;
    localparam logic [7:0] idx_balance_undervolt_threshold = 8'h7e;
    localparam logic [7:0] idx_balance_delay_control = 8'h7f;
    localparam logic [7:0] idx_balance_mode = 8'h80;
    localparam logic [7:0] idx_status = 8'h81;
    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int expiry_w = 10;
    localparam int level_w = 14;
    localparam int level_lsb = 2;
    localparam int sel_bit = 0;
    localparam int notify_lsb = 8;
    localparam int notify_w = 2;
    localparam int cal_w = 3;
    localparam int mode_w = 3;
    localparam int mode_auto_bit = 2;
    localparam int cell_idx_w = 4;
    // ------------------------------------------------------------
    // reset values and special codes
    // ------------------------------------------------------------
    localparam logic [expiry_w-1:0] expiry_reset = 10'h000;
    localparam logic [expiry_w-1:0] expiry_forever = 10'h3ff;
    localparam logic [level_w-1:0] level_full_scale = 14'h3fff;
    localparam logic [mode_w-1:0] mode_discharge = 3'h1;
    localparam logic [31:0] read_zero = 32'h0000_0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint clk_hz = 50_000_000;
    localparam longint notify_base_s = 3600;
    localparam longint notify_base_cycles = clk_hz * notify_base_s;
    localparam logic [2:0] notify_hours_one = 3'h1;
    localparam logic [2:0] notify_hours_two = 3'h2;
    localparam logic [2:0] notify_hours_four = 3'h4;
endpackage

// *** hdl/cell_result_mem.sv ***
// small memory of per-cell results, registered read port
module cell_result_mem #(
    parameter int cells = 16,
    parameter int aw = 4,
    parameter int dw = 14
) (
    // clock
    input wire logic pclk,
    input wire logic ce,
    // write port
    input wire logic wr_en,
    input wire logic [aw-1:0] wr_addr,
    input wire logic [dw-1:0] wr_data,
    // read port
    input wire logic [aw-1:0] rd_addr,
    output logic [dw-1:0] rd_data
);
    logic [dw-1:0] mem [cells];

    always_ff @(posedge pclk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // cell_result_mem

// *** tb/cell_balance_monitor.sv ***
// checker of apb timing and register side effects of the balance configuration bank
module cell_balance_monitor (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // measurement side and outputs
    input wire logic scan_active,
    input wire logic [13:0] cell_reading,
    input wire logic [9:0] cell14_expiry_time,
    input wire logic cell14_timer_forever,
    input wire logic cell14_timer_expired,
    input wire logic [13:0] undervolt_exit_level,
    input wire logic balance_suspend,
    input wire logic [2:0] balance_mode_select,
    input wire logic [2:0] calibration_period_select,
    input wire logic write_rejected_alert
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write commits at the edge that sees pready with the access phase
    wire acc = ce & psel & penable & pwrite & pready;
    wire [13:0] wr_level = pwdata[15:2];
    wire rej = acc && paddr == 32'h0000_01f8 && pwdata[0] && scan_active && !balance_mode_select[2];
    chk_ready_pulse: assert property (psel && !penable && ce |=> pready ##1 !pready)
        else $error("ready is not a single pulse after setup");
    chk_expiry_forever: assert property (ce && cell14_expiry_time == 10'h3ff |=> cell14_timer_forever)
        else $error("all-ones expiry not flagged forever");
    chk_expiry_zero: assert property (ce && cell14_expiry_time == 10'h000 |=> cell14_timer_expired)
        else $error("zero expiry not flagged expired");
    chk_suspend_level: assert property (ce |=> balance_suspend == ($past(cell_reading) < undervolt_exit_level))
        else $error("suspend does not follow reading below level");
    chk_lock_expiry: assert property (acc && paddr == 32'h0000_01f4 && balance_mode_select[2] |=> $stable(cell14_expiry_time))
        else $error("expiry changed under automated mode");
    chk_lock_delay: assert property (acc && paddr == 32'h0000_01fc && (balance_mode_select[2] || balance_mode_select == 3'h1)
        |=> $stable(calibration_period_select)[*2])
        else $error("delay control changed while locked");
    chk_reject_alert: assert property (rej |=> write_rejected_alert)
        else $error("rejected write raised no alert");
    chk_reject_hold: assert property (rej |=> $stable(undervolt_exit_level)[*3])
        else $error("rejected write changed the level");
    chk_level_direct: assert property (acc && paddr == 32'h0000_01f8 && !pwdata[0] && !balance_mode_select[2]
        |=> ##1 undervolt_exit_level == $past(wr_level, 2))
        else $error("direct level write not loaded");
    cover property (rej);
    cover property (acc && paddr == 32'h0000_01f4 && balance_mode_select[2]);
    cover property ($rose(cell14_timer_forever));
endmodule // cell_balance_monitor

bind cell_balance_config_regs cell_balance_monitor i_mon (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .scan_active(scan_active),
    .cell_reading(cell_reading),
    .cell14_expiry_time(cell14_expiry_time),
    .cell14_timer_forever(cell14_timer_forever),
    .cell14_timer_expired(cell14_timer_expired),
    .undervolt_exit_level(undervolt_exit_level),
    .balance_suspend(balance_suspend),
    .balance_mode_select(balance_mode_select),
    .calibration_period_select(calibration_period_select),
    .write_rejected_alert(write_rejected_alert)
);

// *** tb/testbench.sv ***
// self-checking bench for the balance configuration register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, scan_active = 0, extreme_search_polarity = 0;
    logic result_wr = 0, balancing_running = 0, shutdown_line_hold = 0, err, ce = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, e, dl;
    logic [3:0] lowest_cell_index = 0, result_idx = 0;
    logic [13:0] result_data = 0, cell_reading = 0, undervolt_exit_level;
    logic [9:0] cell14_expiry_time;
    logic [2:0] balance_mode_select, calibration_period_select;
    logic pready, pslverr, cell14_timer_forever, cell14_timer_expired, balance_suspend;
    logic write_rejected_alert, progress_notify_alert;
    int failures = 0, compares = 0, cyc = 0;
    always #10 pclk = ~pclk;
    // a short notify unit keeps the hour-scale counts inside the run
    cell_balance_config_regs #(.notify_unit_cycles(10), .cells(16)) i_dut (.*);
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            summarize;
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdchk(32'h0000_01f4, 0);
        chk(cell14_timer_expired, 1);
        rdchk(32'h0000_01f8, 32'h0000_fffc);
        rdchk(32'h0000_01fc, 0);
        apb(1, 32'h0000_01f4, 32'h0000_03ff);
        rdchk(32'h0000_01f4, 32'h0000_03ff);
        chk(cell14_timer_forever, 1);
        $display("reset and expiry test done");
        apb(1, 32'h0000_01f8, 32'h0000_48d0);
        rdchk(32'h0000_01f8, 32'h0000_48d0);
        cell_reading <= 14'h1234;
        repeat (3) @(posedge pclk);
        chk(balance_suspend, 0);
        cell_reading <= 14'h1233;
        repeat (3) @(posedge pclk);
        chk(balance_suspend, 1);
        result_wr <= 1; result_idx <= 4'h5; result_data <= 14'h0abc; lowest_cell_index <= 4'h5;
        @(posedge pclk);
        result_wr <= 0;
        apb(1, 32'h0000_01f8, 32'h0000_fffd);
        repeat (3) @(posedge pclk);
        rdchk(32'h0000_01f8, 32'h0000_2af1);
        extreme_search_polarity <= 1;
        apb(1, 32'h0000_01f8, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        rdchk(32'h0000_01f8, 32'h0000_fffd);
        extreme_search_polarity <= 0;
        apb(1, 32'h0000_01f8, 32'h0000_48d0);
        scan_active <= 1;
        apb(1, 32'h0000_01f8, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk(write_rejected_alert, 1);
        rdchk(32'h0000_01f8, 32'h0000_48d0);
        rdchk(32'h0000_0204, 32'h0000_0001);
        apb(1, 32'h0000_0204, 32'h0000_0003);
        @(posedge pclk);
        chk(write_rejected_alert, 0);
        scan_active <= 0;
        $display("threshold test done");
        ce <= 0;
        cell_reading <= 14'h3fff;
        repeat (3) @(posedge pclk);
        chk(balance_suspend, 1);
        ce <= 1;
        repeat (3) @(posedge pclk);
        chk(balance_suspend, 0);
        $display("clock enable test done");
        e = 32'h0000_03ff;
        dl = 0;
        for (int m = 0; m < 8; m++) begin
            apb(1, 32'h0000_0200, m);
            apb(1, 32'h0000_01f4, m + 1);
            apb(1, 32'h0000_01f8, (m + 1) << 2);
            apb(1, 32'h0000_01fc, m);
            if (m < 4) e = m + 1;
            if (m < 4 && m != 1) dl = m;
            rdchk(32'h0000_01f4, e);
            rdchk(32'h0000_01f8, e << 2);
            rdchk(32'h0000_01fc, dl);
            rdchk(32'h0000_0200, m);
        end
        apb(1, 32'h0000_0200, 0);
        $display("lock test done");
        for (int n = 0; n < 4; n++) begin
            apb(1, 32'h0000_01fc, (n << 8) | (n + 4));
            apb(1, 32'h0000_0204, 32'h0000_0002);
            if (n == 3) shutdown_line_hold <= 1;
            else balancing_running <= 1;
            repeat (n == 0 ? 60 : (10 << (n - 1)) - 3) @(posedge pclk);
            chk(progress_notify_alert, 0);
            if (n != 0) begin
                repeat (6) @(posedge pclk);
                chk(progress_notify_alert, 1);
            end
            balancing_running <= 0; shutdown_line_hold <= 0;
            chk(calibration_period_select, n + 4);
        end
        $display("notify test done");
        apb(0, 32'h0000_0300, 32'h0000_0000);
        chk(rd, 0);
        chk(err, 1);
        $display("unmapped test done");
        summarize;
    end
endmodule // testbench
